// ===== hdl/adc_port_regs.svh
// register offsets, field positions and timing counts of the result port
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH
`define CTRL_OFF 12'h000
`define SAMPLE_OFF 12'h004
`define STATUS_OFF 12'h008
`define CTRL_START_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_SER_BIT 1
`define STAT_MASTER_BIT 2
`define STAT_FRAME_BIT 3
`define STAT_RDERR_BIT 4
`define STAT_MODE_LSB 5
`define SAMPLE_RESET 16'h0000
`define CLK_MHZ 50
`define CONV_WARP_NS 1000
`define CONV_NORMAL_NS 1250
`define CONV_IMPULSE_NS 1500
`define CONV_WARP_CYC ((`CONV_WARP_NS * `CLK_MHZ + 999) / 1000)
`define CONV_NORMAL_CYC ((`CONV_NORMAL_NS * `CLK_MHZ + 999) / 1000)
`define CONV_IMPULSE_CYC ((`CONV_IMPULSE_NS * `CLK_MHZ + 999) / 1000)
`define BITCLK_HALF_NS 40
`define BITCLK_HALF_CYC ((`BITCLK_HALF_NS * `CLK_MHZ + 999) / 1000)
`define FRAME_BITS 16
`define SYNC_W 20
`endif

// ===== hdl/adc_port_pkg.sv
// types shared by the result port modules
`include "adc_port_regs.svh"
package adc_port_pkg;
  typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_HOLD} conv_state_t;
  typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_state_t;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_WARP, MODE_IMPULSE} conv_mode_t;
  typedef struct packed {
    conv_state_t conv;
    logic [6:0] conv_cnt;
    logic [15:0] sample;
    logic [15:0] latched;
    frame_state_t frame;
    logic [4:0] bit_cnt;
    logic [4:0] half_cnt;
    logic phase;
    logic sclk_prev;
    logic cs_prev;
    logic chain_done;
    logic load;
    logic rderr;
    logic rderr_seen;
    logic [15:0] pin_out;
    logic [15:0] pin_oe;
    logic busy;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } port_state_t;
  typedef struct packed {
    logic [15:0] bits;
  } shift_state_t;
  typedef struct packed {
    logic [`SYNC_W-1:0] ff1;
    logic [`SYNC_W-1:0] ff2;
    logic [`SYNC_W-1:0] ff3;
    logic [`SYNC_W-1:0] filt;
  } sync_state_t;
endpackage

// ===== hdl/pin_sync.sv
// three-flop pin synchroniser with second/third agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.svh"
module pin_sync (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`SYNC_W-1:0] pins_i,
  output logic [`SYNC_W-1:0] level_o
);
  adc_port_pkg::sync_state_t q;
  adc_port_pkg::sync_state_t n;
  always_comb
  begin
    n = q;
    n.ff1 = pins_i;
    n.ff2 = q.ff1;
    n.ff3 = q.ff2;
    // a change counts only once stages two and three agree
    n.filt = (~(q.ff2 ^ q.ff3) & q.ff3) | ((q.ff2 ^ q.ff3) & q.filt);
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '0;
    else
      q <= n;
  end
  assign level_o = q.filt;
endmodule // pin_sync
`default_nettype wire

// ===== hdl/result_shifter.sv
// result shift register, msb out, chain bits enter at the lsb
`timescale 1ns/1ps
`default_nettype none
module result_shifter (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [15:0] value_i,
  input wire logic shift_i,
  input wire logic chain_i,
  output logic msb_o
);
  adc_port_pkg::shift_state_t q;
  adc_port_pkg::shift_state_t n;
  always_comb
  begin
    n = q;
    // load wins: a coinciding shift edge is dropped
    if (load_i)
      n.bits = value_i;
    else if (shift_i)
      n.bits = {q.bits[14:0], chain_i};
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      q <= '0;
    else
      q <= n;
  end
  assign msb_o = q.bits[15];
endmodule // result_shifter
`default_nettype wire

// ===== hdl/adc_result_port.sv
// converter result port: parallel bus or serial port with apb control
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.svh"
module adc_result_port (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic warp_i,
  input wire logic impulse_i,
  input wire logic port_type_sel_i,
  input wire logic cs_n_i,
  input wire logic [15:0] d_i,
  output logic [15:0] d_o,
  output logic [15:0] d_oe_o,
  output logic busy_o
);
  adc_port_pkg::port_state_t q;
  adc_port_pkg::port_state_t n;
  logic [`SYNC_W-1:0] sync_level;
  logic warp_s;
  logic impulse_s;
  logic port_type_sel;
  logic cs_n_s;
  logic [15:0] pins_s;
  logic clock_source_sel;
  logic frame_marker_polarity_sel;
  logic bit_clock_invert_sel;
  logic read_mode_or_chain_in;
  logic [1:0] bit_clock_divide_sel;
  logic sclk_s;
  logic master;
  logic serial_result_out;
  adc_port_pkg::conv_mode_t mode;
  logic [6:0] conv_last;
  logic [4:0] half_last;
  logic start;
  logic latch;
  logic frame_go;
  logic frame_abort;
  logic shift;
  logic sclk_edge;
  logic access;
  logic chain_bit;

  pin_sync u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pins_i({warp_i, impulse_i, port_type_sel_i, cs_n_i, d_i}),
    .level_o(sync_level)
  );

  assign {warp_s, impulse_s, port_type_sel, cs_n_s, pins_s} = sync_level;
  // shared pins mean configuration while the serial port is selected; the status master bit decodes pin 4 in both modes
  assign clock_source_sel = pins_s[4];
  assign frame_marker_polarity_sel = pins_s[5];
  assign bit_clock_invert_sel = pins_s[6];
  assign read_mode_or_chain_in = pins_s[7];
  assign sclk_s = pins_s[9];
  assign master = !clock_source_sel;
  assign bit_clock_divide_sel = (master && !read_mode_or_chain_in) ? pins_s[3:2] : 2'b00;
  assign chain_bit = master ? 1'b0 : read_mode_or_chain_in;

  always_comb
  begin
    if (warp_s && !impulse_s)
      mode = adc_port_pkg::MODE_WARP;
    else if (impulse_s && !warp_s)
      mode = adc_port_pkg::MODE_IMPULSE;
    else
      mode = adc_port_pkg::MODE_NORMAL;
  end

  always_comb
  begin
    unique case (mode)
      adc_port_pkg::MODE_WARP: conv_last = 7'(`CONV_WARP_CYC - 1);
      adc_port_pkg::MODE_NORMAL: conv_last = 7'(`CONV_NORMAL_CYC - 1);
      adc_port_pkg::MODE_IMPULSE: conv_last = 7'(`CONV_IMPULSE_CYC - 1);
    endcase
  end

  assign half_last = 5'((5'(`BITCLK_HALF_CYC) << bit_clock_divide_sel) - 5'h01);

  result_shifter u_shift (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(q.load),
    .value_i(q.latched),
    .shift_i(shift),
    .chain_i(chain_bit),
    .msb_o(serial_result_out)
  );

  always_comb
  begin
    n = q;
    n.load = 1'b0;
    n.rderr = 1'b0;
    n.ready = 1'b1;
    start = 1'b0;
    latch = 1'b0;
    frame_go = 1'b0;
    frame_abort = 1'b0;
    shift = 1'b0;
    // setup phase stages read data and error for the access phase
    if (psel_i && !penable_i)
    begin
      n.slverr = 1'b0;
      n.rdata = 32'h0000_0000;
      unique case (paddr_i)
        `CTRL_OFF: n.rdata = 32'h0000_0000;
        `SAMPLE_OFF: n.rdata = {16'h0000, q.sample};
        `STATUS_OFF:
        begin
          n.rdata[`STAT_BUSY_BIT] = q.busy;
          n.rdata[`STAT_SER_BIT] = port_type_sel;
          n.rdata[`STAT_MASTER_BIT] = master;
          n.rdata[`STAT_FRAME_BIT] = (q.frame == adc_port_pkg::FRAME_SHIFT);
          n.rdata[`STAT_RDERR_BIT] = q.rderr_seen;
          n.rdata[`STAT_MODE_LSB +: 2] = mode;
        end
        default: n.slverr = 1'b1;
      endcase
    end
    access = psel_i && penable_i && q.ready;
    if (access && pwrite_i && !q.slverr)
    begin
      unique case (paddr_i)
        `CTRL_OFF: start = pwdata_i[`CTRL_START_BIT];
        `SAMPLE_OFF: n.sample = pwdata_i[15:0];
        `STATUS_OFF:
        begin
          if (pwdata_i[`STAT_RDERR_BIT])
            n.rderr_seen = 1'b0;
        end
        default: n.sample = q.sample;
      endcase
    end

    // conversion sequencer; a start while busy is ignored
    unique case (q.conv)
      adc_port_pkg::CONV_IDLE:
      begin
        if (start)
        begin
          n.conv = adc_port_pkg::CONV_RUN;
          n.conv_cnt = 7'h00;
          n.busy = 1'b1;
          if (port_type_sel && master && read_mode_or_chain_in
              && q.frame == adc_port_pkg::FRAME_IDLE)
          begin
            frame_go = 1'b1;
            // last frame emptied the shifter: reload the previous result
            n.load = 1'b1;
          end
        end
      end
      adc_port_pkg::CONV_RUN:
      begin
        if (q.conv_cnt == conv_last)
        begin
          // master frame still running: latching now would corrupt it
          if (port_type_sel && master && q.frame == adc_port_pkg::FRAME_SHIFT)
            n.conv = adc_port_pkg::CONV_HOLD;
          else
            latch = 1'b1;
        end
        else
          n.conv_cnt = q.conv_cnt + 7'h01;
      end
      adc_port_pkg::CONV_HOLD:
      begin
        if (q.frame == adc_port_pkg::FRAME_IDLE)
          latch = 1'b1;
      end
    endcase
    if (latch)
    begin
      n.conv = adc_port_pkg::CONV_IDLE;
      n.busy = 1'b0;
      n.load = 1'b1;
      n.latched = q.sample;
      if (port_type_sel && master && !read_mode_or_chain_in)
        frame_go = 1'b1;
      if (port_type_sel && !master && q.frame == adc_port_pkg::FRAME_SHIFT && !q.chain_done)
      begin
        n.rderr = 1'b1;
        frame_abort = 1'b1;
      end
    end
    // set wins over a software clear in the same cycle
    if (n.rderr)
      n.rderr_seen = 1'b1;

    // serial frame engine
    sclk_edge = bit_clock_invert_sel ? (q.sclk_prev && !sclk_s) : (!q.sclk_prev && sclk_s);
    n.sclk_prev = sclk_s;
    n.cs_prev = cs_n_s;
    unique case (q.frame)
      adc_port_pkg::FRAME_IDLE:
      begin
        if (frame_go || (port_type_sel && !master && q.cs_prev && !cs_n_s))
        begin
          n.frame = adc_port_pkg::FRAME_SHIFT;
          n.bit_cnt = 5'h00;
          n.half_cnt = 5'h00;
          n.phase = 1'b0;
          n.chain_done = 1'b0;
        end
      end
      adc_port_pkg::FRAME_SHIFT:
      begin
        if (master)
        begin
          if (q.half_cnt == half_last)
          begin
            n.half_cnt = 5'h00;
            n.phase = !q.phase;
            if (q.phase)
            begin
              shift = 1'b1;
              n.bit_cnt = q.bit_cnt + 5'h01;
              if (q.bit_cnt == 5'(`FRAME_BITS - 1))
                n.frame = adc_port_pkg::FRAME_IDLE;
            end
          end
          else
            n.half_cnt = q.half_cnt + 5'h01;
        end
        else if (cs_n_s)
          n.frame = adc_port_pkg::FRAME_IDLE;
        else if (sclk_edge)
        begin
          shift = 1'b1;
          if (q.bit_cnt == 5'(`FRAME_BITS - 1))
            n.chain_done = 1'b1;
          if (!q.chain_done)
            n.bit_cnt = q.bit_cnt + 5'h01;
        end
        if (frame_abort)
          n.frame = adc_port_pkg::FRAME_IDLE;
      end
    endcase

    // pin drive
    if (!port_type_sel)
    begin
      n.pin_out = n.latched;
      n.pin_oe = 16'hFFFF;
    end
    else
    begin
      n.pin_out = 16'h0000;
      n.pin_oe = 16'h0000;
      n.pin_out[8] = serial_result_out;
      n.pin_oe[8] = 1'b1;
      n.pin_out[9] = n.phase ^ bit_clock_invert_sel;
      n.pin_oe[9] = master;
      n.pin_out[10] = (master && n.frame == adc_port_pkg::FRAME_SHIFT)
                      ^ frame_marker_polarity_sel;
      n.pin_oe[10] = 1'b1;
      n.pin_out[11] = n.rderr;
      n.pin_oe[11] = !master;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
      q.sample <= `SAMPLE_RESET;
    end
    else
      q <= n;
  end

  assign prdata_o = q.rdata;
  assign pready_o = q.ready;
  assign pslverr_o = q.slverr;
  assign d_o = q.pin_out;
  assign d_oe_o = q.pin_oe;
  assign busy_o = q.busy;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_latched;
    q.conv != adc_port_pkg::CONV_IDLE ##1 (q.conv == adc_port_pkg::CONV_IDLE && q.load);
  endsequence
  sequence s_started;
    start && q.conv == adc_port_pkg::CONV_IDLE;
  endsequence

  property p_parallel_drive;
    !sys_rst_i && !port_type_sel |=> (d_oe_o == 16'hFFFF) && (d_o == q.latched);
  endproperty
  a_parallel_drive: assert property (p_parallel_drive) else $error("parallel bus not driven");
  property p_serial_float;
    port_type_sel |=> (d_oe_o[1:0] == 2'b00) && (d_oe_o[15:12] == 4'h0);
  endproperty
  a_serial_float: assert property (p_serial_float) else $error("unused pins driven");
  property p_divide_float;
    port_type_sel && !(master && !read_mode_or_chain_in) |=> d_oe_o[3:2] == 2'b00;
  endproperty
  a_divide_float: assert property (p_divide_float) else $error("divide pins driven");
  property p_master_clock;
    port_type_sel && master |=> d_oe_o[9] && (d_o[9] == (q.phase ^ $past(bit_clock_invert_sel)));
  endproperty
  a_master_clock: assert property (p_master_clock) else $error("bit clock out wrong");
  property p_slave_clock_in;
    port_type_sel && !master |=> !d_oe_o[9] && d_o[10] == $past(frame_marker_polarity_sel);
  endproperty
  a_slave_clock_in: assert property (p_slave_clock_in) else $error("slave drives clock");
  property p_marker;
    port_type_sel && master
      |=> d_o[10] == ((q.frame == adc_port_pkg::FRAME_SHIFT) ^ $past(frame_marker_polarity_sel));
  endproperty
  a_marker: assert property (p_marker) else $error("frame marker wrong");
  property p_rac_start;
    (port_type_sel && master && !read_mode_or_chain_in) ##0 s_latched
      |-> q.frame == adc_port_pkg::FRAME_SHIFT;
  endproperty
  a_rac_start: assert property (p_rac_start) else $error("read after convert missing");
  property p_rdc_start;
    port_type_sel && master && read_mode_or_chain_in && q.frame == adc_port_pkg::FRAME_IDLE
      ##0 s_started |=> q.frame == adc_port_pkg::FRAME_SHIFT && q.busy;
  endproperty
  a_rdc_start: assert property (p_rdc_start) else $error("read during convert missing");
  property p_msb_first;
    q.load |=> serial_result_out == $past(q.latched[15]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first");
  property p_busy_hold;
    s_started |=> busy_o [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_busy_release;
    $fell(busy_o) |-> q.load;
  endproperty
  a_busy_release: assert property (p_busy_release) else $error("busy fell without latch");
  property p_rderr;
    port_type_sel && !master && latch && q.frame == adc_port_pkg::FRAME_SHIFT && !q.chain_done
      |=> q.rderr && q.frame == adc_port_pkg::FRAME_IDLE ##1 !q.rderr;
  endproperty
  a_rderr: assert property (p_rderr) else $error("incomplete read not flagged");
endmodule // adc_result_port
`default_nettype wire

// ===== sim/host_model.sv
// host side model: config pins, slave bit clock and chip select
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic [15:0] d_o_i,
  input wire logic [15:0] d_oe_i,
  input wire logic src_i,
  input wire logic pol_i,
  input wire logic inv_i,
  input wire logic rd_i,
  input wire logic [1:0] div_i,
  output logic [15:0] d_i_o,
  output logic cs_n_o
);
  logic sclk = 1'b0;
  logic toggle = 1'b0;
  logic [15:0] host_drv;
  logic [16:0] slave_bits = 17'h00000;
  initial
  begin
    cs_n_o = 1'b1;
  end
  always @(posedge clk_i) toggle <= ~toggle;
  always_comb
  begin
    // released pins flip each cycle so stale values never pass
    host_drv = {16{toggle}};
    host_drv[3:2] = div_i;
    host_drv[4] = src_i;
    host_drv[5] = pol_i;
    host_drv[6] = inv_i;
    host_drv[7] = rd_i;
    host_drv[9] = sclk ^ inv_i;
    d_i_o = (d_oe_i & d_o_i) | (~d_oe_i & host_drv);
  end
  task automatic select(input logic v);
    @(posedge clk_i);
    cs_n_o <= v;
    repeat (8) @(posedge clk_i);
  endtask
  // levels held 8 cycles: the pin synchroniser needs at least 2
  task automatic slave_shift(input int n);
    for (int i = 0; i < n; i++)
    begin
      slave_bits = {slave_bits[15:0], d_o_i[8]};
      sclk <= 1'b1;
      repeat (8) @(posedge clk_i);
      sclk <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule // host_model
`default_nettype wire

// ===== sim/adc_result_port_config_tb.sv
// self-checking testbench of the converter result port
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.svh"
module adc_result_port_config_tb;
  localparam int LIMIT = 60000;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, busy_o, cs_n_i;
  logic warp_i = 1'b0;
  logic impulse_i = 1'b0;
  logic port_type_sel_i = 1'b0;
  logic [15:0] d_i, d_o, d_oe_o, smp, prev, bits;
  logic src = 1'b0;
  logic pol = 1'b0;
  logic inv = 1'b0;
  logic rd = 1'b0;
  logic [1:0] div = 2'h0;
  logic [31:0] rd_data;
  logic err, seen, first_busy, prevclk;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi, n, k1, k2;
  adc_result_port dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .warp_i(warp_i),
    .impulse_i(impulse_i), .port_type_sel_i(port_type_sel_i), .cs_n_i(cs_n_i), .d_i(d_i),
    .d_o(d_o), .d_oe_o(d_oe_o), .busy_o(busy_o));
  host_model host (.clk_i(clk_i), .d_o_i(d_o), .d_oe_i(d_oe_o), .src_i(src), .pol_i(pol),
    .inv_i(inv), .rd_i(rd), .div_i(div), .d_i_o(d_i), .cs_n_o(cs_n_i));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      $display("ERROR %0t timeout got %h exp %h", $time, cycles, LIMIT);
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd_data = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic convert();
    apb(1'b1, `CTRL_OFF, 32'h00000001);
    hi = 0;
    repeat (1) @(posedge clk_i);
    while (busy_o === 1'b1 && hi < 3000)
    begin
      hi++;
      @(posedge clk_i);
    end
  endtask
  // bits taken at each active bit clock edge while the marker is active
  task automatic capture();
    n = 0;
    prevclk = 1'b1;
    for (int k = 0; k < 4000 && n < 16; k++)
    begin
      @(posedge clk_i);
      if ((d_o[10] ^ pol) === 1'b1 && (d_o[9] ^ inv) === 1'b1 && prevclk === 1'b0)
      begin
        if (n == 0) first_busy = busy_o;
        if (n == 0) k1 = k;
        if (n == 1) k2 = k;
        bits = {bits[14:0], d_o[8]};
        n++;
      end
      prevclk = d_o[9] ^ inv;
    end
  endtask
  initial
  begin
    void'($urandom(32'h445005ea));
    repeat (12) @(posedge clk_i);
    check(pready_o, 1'b0);
    check(d_oe_o, 16'h0000);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    apb(1'b0, `STATUS_OFF, 32'h0);
    check(rd_data, 32'h00000004);
    apb(1'b0, 12'h00C, 32'h0);
    check(err, 1'b1);
    check(rd_data, 32'h0);
    for (int m = 0; m < 3; m++)
    begin
      warp_i <= (m == 1);
      impulse_i <= (m == 2);
      repeat (8) @(posedge clk_i);
      smp = $urandom;
      apb(1'b1, `SAMPLE_OFF, {16'h0000, smp});
      apb(1'b0, `SAMPLE_OFF, 32'h0);
      check(rd_data, {16'h0000, smp});
      convert();
      check(hi, (m == 0) ? 63 : (m == 1) ? 50 : 75);
      repeat (2) @(posedge clk_i);
      check(d_o, smp);
      check(d_oe_o, 16'hFFFF);
      apb(1'b0, `STATUS_OFF, 32'h0);
      check(rd_data & 32'h00000063, m << 5);
      prev = smp;
    end
    port_type_sel_i <= !port_type_sel_i;
    for (int i = 0; i < 3; i++)
    begin
      pol <= i[0];
      inv <= (i == 1);
      rd <= (i == 2);
      div <= $urandom;
      repeat (12) @(posedge clk_i);
      check(d_oe_o, 16'h0700);
      check(d_o[10], pol);
      check(d_o[9], inv);
      smp = $urandom;
      apb(1'b1, `SAMPLE_OFF, {16'h0000, smp});
      fork
        convert();
        capture();
      join
      check(bits, rd ? prev : smp);
      check(first_busy, rd);
      check(k2 - k1, rd ? 4 : (4 << div));
      prev = smp;
      repeat (20) @(posedge clk_i);
    end
    src <= !src;
    pol <= 1'b0;
    inv <= $urandom;
    rd <= $urandom;
    repeat (10) @(posedge clk_i);
    check(d_oe_o, 16'h0D00);
    smp = $urandom;
    apb(1'b1, `SAMPLE_OFF, {16'h0000, smp});
    convert();
    host.select(1'b0);
    host.slave_shift(17);
    host.select(1'b1);
    check(host.slave_bits, {smp, rd});
    host.select(1'b0);
    host.slave_shift(4);
    seen = 1'b0;
    fork
      convert();
      for (int k = 0; k < 200; k++)
      begin
        @(posedge clk_i);
        if (d_o[11] === 1'b1) seen = 1'b1;
      end
    join
    check(seen, 1'b1);
    apb(1'b0, `STATUS_OFF, 32'h0);
    check(rd_data[4], 1'b1);
    apb(1'b1, `STATUS_OFF, 32'h00000010);
    apb(1'b0, `STATUS_OFF, 32'h0);
    check(rd_data[4], 1'b0);
    host.select(1'b1);
    summarize();
  end
endmodule // adc_result_port_config_tb
`default_nettype wire
